// ==== rtl/ddrcd_cfg.svh ====
`ifndef DDRCD_CFG_SVH
`define DDRCD_CFG_SVH

// ----------------------------------------------------------------
// address and field positions
// ----------------------------------------------------------------
`define DDRCD_ADDR_W 13
`define DDRCD_BA_W 2
`define DDRCD_COL_W 10
`define DDRCD_AP_BIT 10
`define DDRCD_BA_BASE 2'h0
`define DDRCD_BA_EXT 2'h1
`define DDRCD_MR_DLL_RST_BIT 8
`define DDRCD_EMR_DLL_DIS_BIT 0
`define DDRCD_EMR_DRV_BIT 1
`define DDRCD_EMR_QSC_BIT 2

// ----------------------------------------------------------------
// reset values, timing and data width
// ----------------------------------------------------------------
`define DDRCD_MR_RST 13'h0000
`define DDRCD_EMR_RST 13'h0000
`define DDRCD_ROW_RST 13'h0000
`define DDRCD_DLL_LOCK_CYC 200
`define DDRCD_DATA_W 8

`endif

// ==== rtl/ddrcd_pkg.sv ====
`include "ddrcd_cfg.svh"

package ddrcd_pkg;

    // ------------------------------------------------------------
    // command encodings and states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        DDRCD_CMD_NOP,
        DDRCD_CMD_ACT,
        DDRCD_CMD_RD,
        DDRCD_CMD_WR,
        DDRCD_CMD_BST,
        DDRCD_CMD_PRE,
        DDRCD_CMD_AREF,
        DDRCD_CMD_SREF,
        DDRCD_CMD_LMR_BASE,
        DDRCD_CMD_LMR_EXT,
        DDRCD_CMD_LMR_RSVD
    } ddrcd_cmd_t;

    typedef enum logic {
        DDRCD_ST_RUN,
        DDRCD_ST_SELF_REF
    } ddrcd_state_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic cs_b;
        logic ras_b;
        logic cas_b;
        logic we_b;
    } ddrcd_pins_t;

    typedef struct packed {
        ddrcd_cmd_t cmd;
        logic [`DDRCD_BA_W-1:0] bank;
        logic [`DDRCD_ADDR_W-1:0] addr;
    } ddrcd_req_t;

    typedef struct packed {
        logic act;
        logic rd;
        logic wr;
        logic bst;
        logic pre;
        logic aref;
        logic lmr;
    } ddrcd_evt_t;

endpackage : ddrcd_pkg

// ==== rtl/ddrcd_decode.sv ====
`timescale 1ns/10ps
`include "ddrcd_cfg.svh"

module ddrcd_decode (
    input ddrcd_pkg::ddrcd_pins_t i_pins,
    input logic i_cke,
    input logic [`DDRCD_BA_W-1:0] i_ba,
    input logic [`DDRCD_ADDR_W-1:0] i_addr,
    output ddrcd_pkg::ddrcd_req_t o_req
);
    import ddrcd_pkg::*;

    // ------------------------------------------------------------
    // truth table
    // ------------------------------------------------------------
    always_comb begin
        o_req.bank = i_ba;
        o_req.addr = i_addr;
        o_req.cmd = DDRCD_CMD_NOP;
        if (!i_pins.cs_b) begin
            case ({i_pins.ras_b, i_pins.cas_b, i_pins.we_b})
                3'h3: o_req.cmd = DDRCD_CMD_ACT;
                3'h5: o_req.cmd = DDRCD_CMD_RD;
                3'h4: o_req.cmd = DDRCD_CMD_WR;
                3'h6: o_req.cmd = DDRCD_CMD_BST;
                3'h2: o_req.cmd = DDRCD_CMD_PRE;
                3'h1: o_req.cmd = i_cke ? DDRCD_CMD_AREF
                                        : DDRCD_CMD_SREF;
                3'h0: begin
                    if (i_ba == `DDRCD_BA_BASE) begin
                        o_req.cmd = DDRCD_CMD_LMR_BASE;
                    end else if (i_ba == `DDRCD_BA_EXT) begin
                        o_req.cmd = DDRCD_CMD_LMR_EXT;
                    end else begin
                        o_req.cmd = DDRCD_CMD_LMR_RSVD;
                    end
                end
                default: o_req.cmd = DDRCD_CMD_NOP;
            endcase
            // clock-enable low only carries self refresh entry
            if (!i_cke && o_req.cmd != DDRCD_CMD_SREF) begin
                o_req.cmd = DDRCD_CMD_NOP;
            end
        end
    end

endmodule : ddrcd_decode

// ==== rtl/ddrcd_dll_timer.sv ====
`timescale 1ns/10ps

module ddrcd_dll_timer #(
    parameter int LOCK_CYC = 200
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_start,
    input wire logic i_dll_on,
    output logic o_ready
);
    import ddrcd_pkg::*;

    localparam int CNT_W = $clog2(LOCK_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(LOCK_CYC);

    generate
        if (LOCK_CYC < 1) begin : g_bad_lock
            $error("LOCK_CYC must be at least one");
        end
    endgenerate

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    // ------------------------------------------------------------
    // lock counter
    // ------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        if (i_start || !i_dll_on) begin
            cnt_d = '0;
        end else if (cnt_q != CNT_MAX) begin
            cnt_d = cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign o_ready = i_dll_on && (cnt_q == CNT_MAX);

endmodule : ddrcd_dll_timer

// ==== rtl/ddrcd_top.sv ====
`timescale 1ns/10ps
`include "ddrcd_cfg.svh"


module ddrcd_top #(
    parameter int DATA_W = `DDRCD_DATA_W,
    parameter int LOCK_CYC = `DDRCD_DLL_LOCK_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_cke,
    input ddrcd_pkg::ddrcd_pins_t i_pins,
    input wire logic [`DDRCD_BA_W-1:0] i_ba,
    input wire logic [`DDRCD_ADDR_W-1:0] i_addr,
    input wire logic i_wr_valid,
    input wire logic i_wr_mask,
    input wire logic [DATA_W-1:0] i_wr_data,
    output ddrcd_pkg::ddrcd_evt_t o_evt,
    output logic [`DDRCD_BA_W-1:0] o_bank,
    output logic [`DDRCD_ADDR_W-1:0] o_row,
    output logic [`DDRCD_COL_W-1:0] o_col,
    output logic o_auto_pre,
    output logic o_pre_all,
    output logic [`DDRCD_ADDR_W-1:0] o_refresh_row,
    output logic o_self_refresh,
    output logic [`DDRCD_ADDR_W-1:0] o_mode_reg,
    output logic [`DDRCD_ADDR_W-1:0] o_ext_mode_reg,
    output logic o_drive_reduced,
    output logic o_dll_on,
    output logic o_dll_reset,
    output logic o_read_ok,
    output logic o_read_early,
    output logic o_wr_en,
    output logic [DATA_W-1:0] o_wr_data
);
    import ddrcd_pkg::*;

    generate
        if (DATA_W < 1 || LOCK_CYC < 9) begin : g_bad_width
            $error("DATA_W must be at least one, LOCK_CYC at least nine");
        end
    endgenerate

    ddrcd_req_t req;
    ddrcd_state_t st_q, st_d;
    ddrcd_evt_t evt_q, evt_d;
    logic [`DDRCD_BA_W-1:0] bank_q, bank_d;
    logic [`DDRCD_ADDR_W-1:0] row_q, row_d;
    logic [`DDRCD_COL_W-1:0] col_q, col_d;
    logic ap_q, ap_d;
    logic pre_all_q, pre_all_d;
    logic [`DDRCD_ADDR_W-1:0] ref_row_q, ref_row_d;
    logic [`DDRCD_ADDR_W-1:0] mr_q, mr_d;
    logic [`DDRCD_ADDR_W-1:0] emr_q, emr_d;
    logic dll_on_q, dll_on_d;
    logic dll_rst_q, dll_rst_d;
    logic rd_early_q, rd_early_d;
    logic dll_start;
    logic dll_ready;
    logic wr_en_q, wr_en_d;
    logic [DATA_W-1:0] wr_data_q, wr_data_d;

    // ------------------------------------------------------------
    // decode and lock timer
    // ------------------------------------------------------------
    ddrcd_decode u_decode (
        .i_pins (i_pins),
        .i_cke (i_cke),
        .i_ba (i_ba),
        .i_addr (i_addr),
        .o_req (req)
    );

    ddrcd_dll_timer #(
        .LOCK_CYC (LOCK_CYC)
    ) u_dll_timer (
        .i_ref_clk (i_ref_clk),
        .i_rst_b (i_rst_b),
        .i_start (dll_start),
        .i_dll_on (dll_on_q),
        .o_ready (dll_ready)
    );

    // ------------------------------------------------------------
    // command execution
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        evt_d = '0;
        bank_d = bank_q;
        row_d = row_q;
        col_d = col_q;
        ap_d = ap_q;
        pre_all_d = 1'b0;
        ref_row_d = ref_row_q;
        mr_d = mr_q;
        emr_d = emr_q;
        dll_on_d = dll_on_q;
        dll_rst_d = 1'b0;
        rd_early_d = 1'b0;
        dll_start = 1'b0;
        case (st_q)
            DDRCD_ST_RUN: begin
                case (req.cmd)
                    DDRCD_CMD_ACT: begin
                        evt_d.act = 1'b1;
                        bank_d = req.bank;
                        row_d = req.addr;
                    end
                    DDRCD_CMD_RD, DDRCD_CMD_WR: begin
                        evt_d.rd = (req.cmd == DDRCD_CMD_RD);
                        evt_d.wr = (req.cmd == DDRCD_CMD_WR);
                        bank_d = req.bank;
                        col_d = req.addr[`DDRCD_COL_W-1:0];
                        ap_d = req.addr[`DDRCD_AP_BIT];
                        // flag a read issued before the DLL has locked
                        rd_early_d = (req.cmd == DDRCD_CMD_RD)
                                     && !dll_ready;
                    end
                    DDRCD_CMD_BST: begin
                        evt_d.bst = 1'b1;
                    end
                    DDRCD_CMD_PRE: begin
                        evt_d.pre = 1'b1;
                        pre_all_d = req.addr[`DDRCD_AP_BIT];
                        if (!req.addr[`DDRCD_AP_BIT]) begin
                            bank_d = req.bank;
                        end
                    end
                    DDRCD_CMD_AREF: begin
                        evt_d.aref = 1'b1;
                        ref_row_d = ref_row_q + `DDRCD_ADDR_W'(1);
                    end
                    DDRCD_CMD_SREF: begin
                        st_d = DDRCD_ST_SELF_REF;
                    end
                    DDRCD_CMD_LMR_BASE: begin
                        evt_d.lmr = 1'b1;
                        mr_d = req.addr;
                        mr_d[`DDRCD_MR_DLL_RST_BIT] = 1'b0;
                        dll_rst_d = req.addr[`DDRCD_MR_DLL_RST_BIT];
                        // a DLL reset restarts the lock wait
                        dll_start = req.addr[`DDRCD_MR_DLL_RST_BIT];
                    end
                    DDRCD_CMD_LMR_EXT: begin
                        evt_d.lmr = 1'b1;
                        emr_d = req.addr;
                        dll_on_d = !req.addr[`DDRCD_EMR_DLL_DIS_BIT];
                        dll_start = !req.addr[`DDRCD_EMR_DLL_DIS_BIT];
                    end
                    default: begin
                        evt_d = '0;
                    end
                endcase
            end
            DDRCD_ST_SELF_REF: begin
                if (i_cke) begin
                    st_d = DDRCD_ST_RUN;
                    dll_on_d = 1'b1;
                    dll_start = 1'b1;
                end
            end
            default: st_d = DDRCD_ST_RUN;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q <= DDRCD_ST_RUN;
            evt_q <= '0;
            bank_q <= '0;
            row_q <= '0;
            col_q <= '0;
            ap_q <= 1'b0;
            pre_all_q <= 1'b0;
            ref_row_q <= `DDRCD_ROW_RST;
            mr_q <= `DDRCD_MR_RST;
            emr_q <= `DDRCD_EMR_RST;
            dll_on_q <= 1'b0;
            dll_rst_q <= 1'b0;
            rd_early_q <= 1'b0;
        end else begin
            st_q <= st_d;
            evt_q <= evt_d;
            bank_q <= bank_d;
            row_q <= row_d;
            col_q <= col_d;
            ap_q <= ap_d;
            pre_all_q <= pre_all_d;
            ref_row_q <= ref_row_d;
            mr_q <= mr_d;
            emr_q <= emr_d;
            dll_on_q <= dll_on_d;
            dll_rst_q <= dll_rst_d;
            rd_early_q <= rd_early_d;
        end
    end

    // ------------------------------------------------------------
    // write data masking
    // ------------------------------------------------------------
    always_comb begin
        wr_en_d = i_wr_valid && !i_wr_mask;
        wr_data_d = wr_en_d ? i_wr_data : wr_data_q;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_en_q <= 1'b0;
            wr_data_q <= '0;
        end else begin
            wr_en_q <= wr_en_d;
            wr_data_q <= wr_data_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_evt = evt_q;
    assign o_bank = bank_q;
    assign o_row = row_q;
    assign o_col = col_q;
    assign o_auto_pre = ap_q;
    assign o_pre_all = pre_all_q;
    assign o_refresh_row = ref_row_q;
    assign o_self_refresh = (st_q == DDRCD_ST_SELF_REF);
    assign o_mode_reg = mr_q;
    assign o_ext_mode_reg = emr_q;
    assign o_drive_reduced = emr_q[`DDRCD_EMR_DRV_BIT];
    assign o_dll_on = dll_on_q;
    assign o_dll_reset = dll_rst_q;
    assign o_read_ok = dll_ready;
    assign o_read_early = rd_early_q;
    assign o_wr_en = wr_en_q;
    assign o_wr_data = wr_data_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic run;
    logic sel;
    logic pin_act, pin_rd, pin_pre, pin_ref, pin_lmr;
    assign run = (st_q == DDRCD_ST_RUN) && i_cke;
    assign sel = !i_pins.cs_b && run;
    assign pin_act = sel && !i_pins.ras_b && i_pins.cas_b && i_pins.we_b;
    assign pin_rd = sel && i_pins.ras_b && !i_pins.cas_b && i_pins.we_b;
    assign pin_pre = sel && !i_pins.ras_b && i_pins.cas_b && !i_pins.we_b;
    assign pin_ref = !i_pins.ras_b && !i_pins.cas_b && i_pins.we_b;
    assign pin_lmr = sel && !i_pins.ras_b && !i_pins.cas_b && !i_pins.we_b;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    property p_lmr_ext;
        pin_lmr && i_ba == 2'h1 |=> o_ext_mode_reg == $past(i_addr);
    endproperty
    a_lmr_ext: assert property (p_lmr_ext)
        else $error("extended register not loaded");

    property p_emr_hold;
        !(pin_lmr && i_ba == 2'h1) |=> $stable(o_ext_mode_reg);
    endproperty
    a_emr_hold: assert property (p_emr_hold)
        else $error("extended register changed without a load");

    property p_lmr_base;
        pin_lmr && i_ba == 2'h0 |=> o_mode_reg[8] == 1'b0
            && o_dll_reset == $past(i_addr[8]) ##1 !o_dll_reset;
    endproperty
    a_lmr_base: assert property (p_lmr_base)
        else $error("base register load or DLL reset pulse wrong");

    property p_sref_exit;
        o_self_refresh && i_cke |=> o_dll_on && !o_self_refresh
            ##1 !o_read_ok;
    endproperty
    a_sref_exit: assert property (p_sref_exit)
        else $error("DLL not re-enabled after self refresh");

    property p_deselect;
        i_pins.cs_b |=> o_evt == '0;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("deselect started an operation");

    property p_act;
        pin_act |=> o_evt.act && o_bank == $past(i_ba)
            && o_row == $past(i_addr);
    endproperty
    a_act: assert property (p_act)
        else $error("active not captured");

    property p_rd;
        pin_rd |=> o_evt.rd && o_col == $past(i_addr[9:0])
            && o_auto_pre == $past(i_addr[10]);
    endproperty
    a_rd: assert property (p_rd)
        else $error("read column or auto precharge wrong");

    property p_pre;
        pin_pre |=> o_evt.pre && o_pre_all == $past(i_addr[10]);
    endproperty
    a_pre: assert property (p_pre)
        else $error("precharge scope wrong");

    property p_aref;
        sel && pin_ref |=> o_evt.aref
            && o_refresh_row == $past(o_refresh_row) + 13'h0001;
    endproperty
    a_aref: assert property (p_aref)
        else $error("auto refresh did not advance the row counter");

    property p_sref_quiet;
        o_self_refresh && !i_cke |=> o_evt == '0 && o_self_refresh
            && $stable(o_mode_reg);
    endproperty
    a_sref_quiet: assert property (p_sref_quiet)
        else $error("command acted on during self refresh");

    property p_mask;
        i_wr_valid && i_wr_mask |=> !o_wr_en && $stable(o_wr_data);
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked write data passed");

    property p_lock;
        dll_start |=> !o_read_ok [*8];
    endproperty
    a_lock: assert property (p_lock)
        else $error("read allowed too soon after DLL enable");

    c_sref: cover property (pin_ref && !i_cke && !i_pins.cs_b
        && st_q == DDRCD_ST_RUN ##1 o_self_refresh ##[1:20] o_dll_on);
    c_rd_ap: cover property (pin_rd && i_addr[10]);
    c_early: cover property (o_read_early);
    c_mask: cover property (i_wr_valid && i_wr_mask ##1 i_wr_valid);

endmodule : ddrcd_top

// ==== sim/ddrcd_ctl_model.sv ====
`timescale 1ns/10ps
`include "ddrcd_cfg.svh"

module ddrcd_ctl_model #(
    parameter int LOCK_CYC = 20,
    parameter int MRD_CYC = 2
) (
    input wire logic i_ref_clk,
    output logic o_cke,
    output ddrcd_pkg::ddrcd_pins_t o_pins,
    output logic [`DDRCD_BA_W-1:0] o_ba,
    output logic [`DDRCD_ADDR_W-1:0] o_addr,
    output logic o_wr_valid,
    output logic o_wr_mask,
    output logic [7:0] o_wr_data
);
    import ddrcd_pkg::*;

    initial begin
        o_cke = 1'b1;
        o_pins = ddrcd_pins_t'(4'h7);
        o_ba = 2'h0;
        o_addr = 13'h0000;
        o_wr_valid = 1'b0;
        o_wr_mask = 1'b0;
        o_wr_data = 8'h00;
    end

    // ----------------------------------------------------------------
    // command side
    // ----------------------------------------------------------------
    // released bank and address lines show the inverse of their last value; command pins return to 4'h7
    task automatic idle();
        @(negedge i_ref_clk);
        o_pins <= ddrcd_pins_t'(4'h7);
        o_ba <= ~o_ba;
        o_addr <= ~o_addr;
    endtask : idle

    task automatic cmd(input logic [3:0] p, input logic [1:0] b,
                       input logic [12:0] a);
        @(negedge i_ref_clk);
        o_cke <= 1'b1;
        o_pins <= ddrcd_pins_t'(p);
        o_ba <= b;
        o_addr <= a;
        idle();
    endtask : cmd

    // clock-enable low only around self refresh
    task automatic cmd_low(input logic [3:0] p);
        @(negedge i_ref_clk);
        o_cke <= 1'b0;
        o_pins <= ddrcd_pins_t'(p);
        idle();
    endtask : cmd_low

    task automatic sref_exit();
        @(negedge i_ref_clk);
        o_cke <= 1'b1;
        idle();
    endtask : sref_exit

    task automatic mrd();
        repeat (MRD_CYC) idle();
    endtask : mrd

    task automatic wait_lock();
        repeat (LOCK_CYC) idle();
    endtask : wait_lock

    // ----------------------------------------------------------------
    // write data side
    // ----------------------------------------------------------------
    task automatic wdata(input logic m, input logic [7:0] d);
        @(negedge i_ref_clk);
        o_wr_valid <= 1'b1;
        o_wr_mask <= m;
        o_wr_data <= d;
        @(negedge i_ref_clk);
        o_wr_valid <= 1'b0;
        o_wr_mask <= ~m;
        o_wr_data <= ~d;
    endtask : wdata

endmodule : ddrcd_ctl_model

// ==== sim/ddr_sdram_command_decode_test.sv ====
`timescale 1ns/10ps
`include "ddrcd_cfg.svh"

module ddr_sdram_command_decode_test;
    import ddrcd_pkg::*;

    localparam int LOCK = 20;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cke, wv, wm, ap, pall, sref, drv, dll, dllr, rok, rearly, wen;
    ddrcd_pins_t pins;
    ddrcd_evt_t evt;
    logic [1:0] ba, bank;
    logic [12:0] addr, row, rrow, mr, emr;
    logic [9:0] col;
    logic [7:0] wd, wq;
    int failures = 0;
    int compares = 0;

    always #12.5 clk = ~clk;

    ddrcd_ctl_model #(.LOCK_CYC(LOCK), .MRD_CYC(2)) ctl (
        .i_ref_clk(clk), .o_cke(cke), .o_pins(pins), .o_ba(ba),
        .o_addr(addr), .o_wr_valid(wv), .o_wr_mask(wm), .o_wr_data(wd));

    ddrcd_top #(.DATA_W(8), .LOCK_CYC(LOCK)) dut (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_cke(cke), .i_pins(pins),
        .i_ba(ba), .i_addr(addr), .i_wr_valid(wv), .i_wr_mask(wm),
        .i_wr_data(wd), .o_evt(evt), .o_bank(bank), .o_row(row),
        .o_col(col), .o_auto_pre(ap), .o_pre_all(pall),
        .o_refresh_row(rrow), .o_self_refresh(sref), .o_mode_reg(mr),
        .o_ext_mode_reg(emr), .o_drive_reduced(drv), .o_dll_on(dll),
        .o_dll_reset(dllr), .o_read_ok(rok), .o_read_early(rearly),
        .o_wr_en(wen), .o_wr_data(wq));

    // ----------------------------------------------------------------
    // checking and ending
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [12:0] s,
                       input logic [12:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_mode_lock();
        chk("dll", dll, 1'b0);
        ctl.cmd(4'h0, 2'h1, 13'h0006);
        chk("evt", evt, 7'h01);
        chk("emr", emr, 13'h0006);
        chk("dll", dll, 1'b1);
        chk("drv", drv, 1'b1);
        ctl.mrd();
        ctl.cmd(4'h0, 2'h0, 13'h0132);
        chk("dllr", dllr, 1'b1);
        chk("mr", mr, 13'h0032);
        chk("emr", emr, 13'h0006);
        ctl.mrd();
        ctl.cmd(4'h0, 2'h2, 13'h1FFF);
        chk("evt", evt, 7'h00);
        chk("mr", mr, 13'h0032);
        chk("emr", emr, 13'h0006);
        ctl.cmd(4'h5, 2'h3, 13'h07FF);
        chk("evt", evt, 7'h20);
        chk("col", col, 10'h3FF);
        chk("bank", bank, 2'h3);
        chk("ap", ap, 1'b1);
        chk("rearly", rearly, 1'b1);
        repeat (8) ctl.idle();
        chk("rok", rok, 1'b0);
        ctl.wait_lock();
        chk("rok", rok, 1'b1);
        ctl.cmd(4'h5, 2'h1, 13'h0012);
        chk("rearly", rearly, 1'b0);
        chk("ap", ap, 1'b0);
        chk("col", col, 10'h012);
        ctl.cmd(4'h6, 2'h0, 13'h0000);
        chk("evt", evt, 7'h08);
    endtask : t_mode_lock

    task automatic t_cmds();
        ctl.cmd(4'h3, 2'h2, 13'h1ABC);
        chk("evt", evt, 7'h40);
        chk("row", row, 13'h1ABC);
        chk("bank", bank, 2'h2);
        ctl.cmd(4'h4, 2'h1, 13'h0600);
        chk("evt", evt, 7'h10);
        chk("col", col, 10'h200);
        chk("ap", ap, 1'b1);
        chk("row", row, 13'h1ABC);
        ctl.cmd(4'h2, 2'h2, 13'h0000);
        chk("evt", evt, 7'h04);
        chk("pall", pall, 1'b0);
        chk("bank", bank, 2'h2);
        ctl.cmd(4'h2, 2'h1, 13'h0400);
        chk("pall", pall, 1'b1);
        for (int p = 7; p < 16; p++) begin
            ctl.cmd(p[3:0], 2'h3, 13'h1555);
            chk("evt", evt, 7'h00);
            chk("pall", pall, 1'b0);
        end
    endtask : t_cmds

    task automatic t_refresh();
        ctl.cmd(4'h1, 2'h3, 13'h1FFF);
        chk("evt", evt, 7'h02);
        chk("rrow", rrow, 13'h0001);
        ctl.cmd(4'h1, 2'h0, 13'h0000);
        chk("rrow", rrow, 13'h0002);
        ctl.cmd(4'h0, 2'h1, 13'h0001);
        chk("dll", dll, 1'b0);
        ctl.mrd();
        ctl.cmd_low(4'h1);
        chk("sref", sref, 1'b1);
        chk("evt", evt, 7'h00);
        ctl.cmd_low(4'h3);
        chk("evt", evt, 7'h00);
        chk("rrow", rrow, 13'h0002);
        ctl.sref_exit();
        chk("sref", sref, 1'b0);
        chk("dll", dll, 1'b1);
        chk("rok", rok, 1'b0);
        chk("emr", emr, 13'h0001);
        repeat (LOCK - 1) ctl.idle();
        chk("rok", rok, 1'b0);
        ctl.idle();
        chk("rok", rok, 1'b1);
    endtask : t_refresh

    task automatic t_mask();
        ctl.wdata(1'b0, 8'hA5);
        chk("wen", wen, 1'b1);
        chk("wq", wq, 8'hA5);
        ctl.wdata(1'b1, 8'h3C);
        chk("wen", wen, 1'b0);
        chk("wq", wq, 8'hA5);
        ctl.wdata(1'b0, 8'h5A);
        chk("wq", wq, 8'h5A);
    endtask : t_mask

    initial begin
        repeat (2000) @(posedge clk);
        failures++;
        test_done();
    end

    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        t_mode_lock();
        t_cmds();
        t_refresh();
        t_mask();
        test_done();
    end

endmodule : ddr_sdram_command_decode_test
